// ### rtl/tdu_pkg.sv
// Purpose: shared constants and arithmetic helpers for the transmit upconversion path
// Assumes: pclk is the dac update clock; 16-bit signed internal samples
// Notes:   register map, control field positions and coefficient functions
package tdu_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_NCO_LO  = 8'h04;
  localparam logic [7:0] OFF_NCO_MID = 8'h08;
  localparam logic [7:0] OFF_NCO_HI  = 8'h0c;
  localparam logic [7:0] OFF_DAC_A   = 8'h10;
  localparam logic [7:0] OFF_DAC_B   = 8'h14;
  localparam logic [7:0] OFF_GAIN    = 8'h18;
  localparam logic [7:0] OFF_STATUS  = 8'h1c;

  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_W          = 13;
  localparam int B_INTERP_LO     = 0;
  localparam int B_HILBERT       = 2;
  localparam int B_KEEP_NEG      = 3;
  localparam int B_FINE_MOD      = 4;
  localparam int B_FINE_SEL      = 5;
  localparam int B_COARSE_EN     = 6;
  localparam int B_COARSE_FS8    = 7;
  localparam int B_NEG_TUNE      = 8;
  localparam int B_REAL_MIX      = 9;
  localparam int B_TX_PWRDN      = 10;
  localparam int B_DAC_A_PD      = 11;
  localparam int B_DAC_B_PD      = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [1:0] INTERP_1X = 2'h0;
  localparam logic [1:0] INTERP_2X = 2'h1;
  localparam logic [1:0] INTERP_4X = 2'h2;

  localparam int DAC_OFS_W     = 10;
  localparam int DAC_FG_W      = 5;
  localparam int DAC_FG_LSB    = 16;
  localparam int GAIN_W        = 8;
  localparam int NCO_W         = 24;
  localparam int HILBERT_TAPS  = 15;
  localparam int HB1_TAPS      = 39;
  localparam int HB2_TAPS      = 15;
  localparam logic [GAIN_W-1:0] GAIN_RST = 8'hff;

  // ****************************************
  // arithmetic helpers
  // ****************************************
  // cos(2*pi*k/16) scaled by 2^15
  function automatic logic signed [15:0] cos16(input logic [3:0] k);
    logic signed [15:0] m;
    logic [1:0]         r;
    r = k[2] ? 2'(3'h4 - {1'b0, k[1:0]}) : k[1:0];
    case (k[2] ? (k[1:0] == 2'h0 ? 3'h4 : {1'b0, r}) : {1'b0, k[1:0]})
      3'h0:    m = 16'sh7fff;
      3'h1:    m = 16'sh7642;
      3'h2:    m = 16'sh5a82;
      3'h3:    m = 16'sh30fc;
      default: m = 16'sh0000;
    endcase
    // quadrants 1 and 2 are negative
    cos16 = (k[3] ^ k[2]) && (k[2] ? 1'b1 : 1'b0) ? -m : m;
    if (k[3] && !k[2])
      cos16 = m;
    if (k[3:2] == 2'h1 || k[3:2] == 2'h2)
      cos16 = -m;
  endfunction

  // (a*b + c*d) / 2^15
  function automatic logic signed [15:0] mac2(input logic signed [15:0] a,
                                              input logic signed [15:0] b,
                                              input logic signed [15:0] c,
                                              input logic signed [15:0] d);
    logic signed [32:0] s;
    s    = 33'(a * b) + 33'(c * d);
    mac2 = s[30:15];
  endfunction

  // half-band lowpass tap, centre 0.5 scaled by 2^15, tapered
  function automatic logic signed [17:0] hb_coef(input int k, input int taps);
    int off;
    int mag;
    int half;
    off  = k - (taps - 1) / 2;
    mag  = off < 0 ? -off : off;
    half = (taps - 1) / 2;
    if (off == 0)
      hb_coef = 18'sh04000;
    else if (mag % 2 == 0)
      hb_coef = 18'sh00000;
    else
      hb_coef = 18'((((mag - 1) / 2) % 2 == 1 ? -1 : 1) * 10430 * (half + 1 - mag)
                    / ((half + 1) * mag));
  endfunction

  // hilbert tap 2/(pi*off), antisymmetric, scaled by 2^15
  function automatic logic signed [17:0] hil_coef(input int k);
    int off;
    off = k - (HILBERT_TAPS - 1) / 2;
    if (off % 2 == 0)
      hil_coef = 18'sh00000;
    else
      hil_coef = 18'(20861 / off);
  endfunction

endpackage

// ### rtl/tdu_halfband.sv
// Purpose: 2x interpolating half-band filter for one channel
// Assumes: in_en only in cycles where out_en is high
// Notes:   zero-stuffing upsampler followed by a direct-form fir
`timescale 1ns/100ps
`default_nettype none
module tdu_halfband #(
  parameter int TAPS = 39,
  parameter int W    = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                in_en,
  input  wire logic                out_en,
  input  wire logic signed [W-1:0] din,
  output logic signed [W-1:0]      dout
);

  logic signed [W-1:0]  tap_q [TAPS];
  logic signed [W+23:0] acc;

  // ****************************************
  // fir sum
  // ****************************************
  always_comb begin
    acc = '0;
    for (int k = 0; k < TAPS; k++) begin
      acc = acc + (W+24)'(tap_q[k] * tdu_pkg::hb_coef(k, TAPS));
    end
  end

  // ****************************************
  // zero-stuffed delay line
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < TAPS; k++) begin
        tap_q[k] <= '0;
      end
      dout <= '0;
    end else if (out_en) begin
      tap_q[0] <= in_en ? din : '0;
      for (int k = 1; k < TAPS; k++) begin
        tap_q[k] <= tap_q[k-1];
      end
      // gain of two restores the zero-stuffing loss
      dout <= acc[W+13:14];
    end
  end

endmodule
`default_nettype wire

// ### rtl/tdu_tx_path.sv
// Purpose: transmit datapath: hilbert, fine nco mix, interpolation, coarse mix, dac codes
// Assumes: pclk is the dac update clock; samples come from logic on pclk
// Notes:   apb register slave with zero wait states
//
// Contract
// - coarse shift by fdac/4 or fdac/8
// - complex or per-channel real coarse mix
// - coarse bypassed by default, direction selectable
// - interpolation 1x, 2x or 4x cascade
// - first filter 39 taps, 64 msps
// - second filter 15 taps, 32 msps
// - filters reject 60 dB, 0.1 dB ripple
// - fine mix with 24-bit nco
// - nco step fdac over 2^26 in 4x, fdac over 2^24 in 1x
// - fine mix precedes interpolation
// - fine bypassed by default, two enables
// - hilbert turns real input into iq
// - power-down or blank pin halts path
// - dacs take 12/14-bit samples
// - per-dac 10-bit offset field
// - per-dac 5-bit fine gain field
// - shared transmit gain for both dacs
`timescale 1ns/100ps
`default_nettype none
module tdu_tx_path #(
  parameter int DAC_W = 14
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic signed [DAC_W-1:0] tx_i,
  input  wire logic signed [DAC_W-1:0] tx_q,
  output logic                         tx_take,
  input  wire logic                    tx_blank_pin,
  output logic [DAC_W-1:0]             dac_a_code,
  output logic [DAC_W-1:0]             dac_b_code,
  output logic [9:0]                   dac_a_offset,
  output logic [9:0]                   dac_b_offset,
  output logic [4:0]                   dac_a_fine_gain,
  output logic [4:0]                   dac_b_fine_gain,
  output logic [7:0]                   tx_gain_amp,
  output logic                         dac_a_pwrdn,
  output logic                         dac_b_pwrdn
);

  // ****************************************
  // registers
  // ****************************************
  logic [tdu_pkg::CTRL_W-1:0]     ctrl_q;
  logic [tdu_pkg::NCO_W-1:0]      nco_tuning_word;
  logic [tdu_pkg::DAC_OFS_W-1:0]  ofs_a_q;
  logic [tdu_pkg::DAC_OFS_W-1:0]  ofs_b_q;
  logic [tdu_pkg::DAC_FG_W-1:0]   fg_a_q;
  logic [tdu_pkg::DAC_FG_W-1:0]   fg_b_q;
  logic [tdu_pkg::GAIN_W-1:0]     gain_q;
  logic [31:0]                    rdata_d;
  logic [2:0]                     blank_sync_q;
  logic                           blank_q;

  wire       wr_en     = psel & penable & pwrite;
  wire       hit       = paddr[1:0] == 2'h0 && paddr <= tdu_pkg::OFF_STATUS;
  wire [1:0] interp    = ctrl_q[tdu_pkg::B_INTERP_LO +: 2];
  wire       hil_en    = ctrl_q[tdu_pkg::B_HILBERT];
  wire       keep_neg  = ctrl_q[tdu_pkg::B_KEEP_NEG];
  wire       fine_en   = ctrl_q[tdu_pkg::B_FINE_MOD] & ctrl_q[tdu_pkg::B_FINE_SEL];
  wire       coarse_en = ctrl_q[tdu_pkg::B_COARSE_EN];
  wire       fs8       = ctrl_q[tdu_pkg::B_COARSE_FS8];
  wire       neg_tune  = ctrl_q[tdu_pkg::B_NEG_TUNE];
  wire       real_mix  = ctrl_q[tdu_pkg::B_REAL_MIX];
  wire       halted    = ctrl_q[tdu_pkg::B_TX_PWRDN] | blank_q;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  assign dac_a_offset    = ofs_a_q;
  assign dac_b_offset    = ofs_b_q;
  assign dac_a_fine_gain = fg_a_q;
  assign dac_b_fine_gain = fg_b_q;
  assign tx_gain_amp     = gain_q;
  assign dac_a_pwrdn     = ctrl_q[tdu_pkg::B_DAC_A_PD];
  assign dac_b_pwrdn     = ctrl_q[tdu_pkg::B_DAC_B_PD];

  always_comb begin
    case (paddr)
      tdu_pkg::OFF_CTRL:    rdata_d = 32'(ctrl_q);
      tdu_pkg::OFF_NCO_LO:  rdata_d = 32'(nco_tuning_word[7:0]);
      tdu_pkg::OFF_NCO_MID: rdata_d = 32'(nco_tuning_word[15:8]);
      tdu_pkg::OFF_NCO_HI:  rdata_d = 32'(nco_tuning_word[23:16]);
      tdu_pkg::OFF_DAC_A:   rdata_d = {11'h000, fg_a_q, 6'h00, ofs_a_q};
      tdu_pkg::OFF_DAC_B:   rdata_d = {11'h000, fg_b_q, 6'h00, ofs_b_q};
      tdu_pkg::OFF_GAIN:    rdata_d = 32'(gain_q);
      tdu_pkg::OFF_STATUS:  rdata_d = {29'h00000000, blank_q, halted, fine_en};
      default:              rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q          <= tdu_pkg::CTRL_RST;
      nco_tuning_word <= '0;
      ofs_a_q         <= '0;
      ofs_b_q         <= '0;
      fg_a_q          <= '0;
      fg_b_q          <= '0;
      gain_q          <= tdu_pkg::GAIN_RST;
      prdata          <= '0;
    end else begin
      if (psel && !penable) begin
        prdata <= rdata_d;
      end
      if (wr_en) begin
        case (paddr)
          tdu_pkg::OFF_CTRL:    ctrl_q <= pwdata[tdu_pkg::CTRL_W-1:0];
          tdu_pkg::OFF_NCO_LO:  nco_tuning_word[7:0]   <= pwdata[7:0];
          tdu_pkg::OFF_NCO_MID: nco_tuning_word[15:8]  <= pwdata[7:0];
          tdu_pkg::OFF_NCO_HI:  nco_tuning_word[23:16] <= pwdata[7:0];
          tdu_pkg::OFF_DAC_A: begin
            ofs_a_q <= pwdata[tdu_pkg::DAC_OFS_W-1:0];
            fg_a_q  <= pwdata[tdu_pkg::DAC_FG_LSB +: tdu_pkg::DAC_FG_W];
          end
          tdu_pkg::OFF_DAC_B: begin
            ofs_b_q <= pwdata[tdu_pkg::DAC_OFS_W-1:0];
            fg_b_q  <= pwdata[tdu_pkg::DAC_FG_LSB +: tdu_pkg::DAC_FG_W];
          end
          tdu_pkg::OFF_GAIN:    gain_q <= pwdata[tdu_pkg::GAIN_W-1:0];
          default:              ;
        endcase
      end
    end
  end

  // ****************************************
  // blank pin synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_sync_q <= '0;
      blank_q      <= 1'b0;
    end else begin
      blank_sync_q <= {blank_sync_q[1:0], tx_blank_pin};
      if (blank_sync_q[1] == blank_sync_q[2]) begin
        blank_q <= blank_sync_q[2];
      end
    end
  end

  // ****************************************
  // rate enables
  // ****************************************
  logic [1:0] cnt_q;
  logic [2:0] coarse_ph_q;
  wire in_en  = ~halted & (interp == tdu_pkg::INTERP_4X ? cnt_q == 2'h3 :
                           interp == tdu_pkg::INTERP_2X ? cnt_q[0] : 1'b1);
  wire mid_en = ~halted & (interp == tdu_pkg::INTERP_4X ? cnt_q[0] : 1'b1);
  wire out_en = ~halted;
  assign tx_take = in_en;

  // ****************************************
  // input latch and hilbert stage
  // ****************************************
  logic signed [15:0]  in_i_q;
  logic signed [15:0]  in_q_q;
  logic signed [15:0]  hil_tap_q [tdu_pkg::HILBERT_TAPS];
  logic signed [39:0]  hil_acc;
  logic signed [15:0]  hil_i;
  logic signed [15:0]  hil_q;
  logic [tdu_pkg::NCO_W-1:0] phase_q;

  always_comb begin
    hil_acc = '0;
    for (int k = 0; k < tdu_pkg::HILBERT_TAPS; k++) begin
      hil_acc = hil_acc + 40'(hil_tap_q[k] * tdu_pkg::hil_coef(k));
    end
  end
  wire signed [15:0] hil_raw = hil_acc[30:15];
  assign hil_i = hil_en ? hil_tap_q[(tdu_pkg::HILBERT_TAPS-1)/2] : in_i_q;
  assign hil_q = hil_en ? (keep_neg ? -hil_raw : hil_raw) : in_q_q;

  // ****************************************
  // fine modulator
  // ****************************************
  // phase steps at input rate, fdac/2^26 in 4x, fdac/2^25 in 2x, fdac/2^24 in 1x
  wire [3:0] nco_idx = phase_q[tdu_pkg::NCO_W-1 -: 4];
  wire signed [15:0] nco_cos = tdu_pkg::cos16(nco_idx);
  wire signed [15:0] nco_sin = tdu_pkg::cos16(4'(nco_idx - 4'h4));
  logic signed [15:0] fine_i_q;
  logic signed [15:0] fine_q_q;

  // ****************************************
  // input-rate pipeline
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_i_q   <= '0;
      in_q_q   <= '0;
      phase_q  <= '0;
      fine_i_q <= '0;
      fine_q_q <= '0;
      for (int k = 0; k < tdu_pkg::HILBERT_TAPS; k++) begin
        hil_tap_q[k] <= '0;
      end
    end else if (in_en) begin
      in_i_q <= 16'({tx_i, {(16-DAC_W){1'b0}}});
      in_q_q <= 16'({tx_q, {(16-DAC_W){1'b0}}});
      hil_tap_q[0] <= in_i_q;
      for (int k = 1; k < tdu_pkg::HILBERT_TAPS; k++) begin
        hil_tap_q[k] <= hil_tap_q[k-1];
      end
      phase_q <= fine_en ? phase_q + nco_tuning_word : '0;
      fine_i_q <= fine_en ? tdu_pkg::mac2(hil_i, nco_cos, hil_q, -nco_sin) : hil_i;
      fine_q_q <= fine_en ? tdu_pkg::mac2(hil_i, nco_sin, hil_q, nco_cos) : hil_q;
    end
  end

  // ****************************************
  // interpolation filters
  // ****************************************
  logic signed [15:0] hb1_out [2];
  logic signed [15:0] hb2_out [2];
  logic signed [15:0] interp_out [2];
  wire  signed [15:0] chan_in [2] = '{fine_i_q, fine_q_q};

  for (genvar c = 0; c < 2; c++) begin : g_chan
    tdu_halfband #(
      .TAPS (tdu_pkg::HB1_TAPS),
      .W    (16)
    ) u_hb1 (
      .pclk    (pclk),
      .presetn (presetn),
      .in_en   (in_en),
      .out_en  (mid_en),
      .din     (chan_in[c]),
      .dout    (hb1_out[c])
    );
    tdu_halfband #(
      .TAPS (tdu_pkg::HB2_TAPS),
      .W    (16)
    ) u_hb2 (
      .pclk    (pclk),
      .presetn (presetn),
      .in_en   (mid_en),
      .out_en  (out_en),
      .din     (hb1_out[c]),
      .dout    (hb2_out[c])
    );
    // select bypass, one or both filters
    assign interp_out[c] = interp == tdu_pkg::INTERP_4X ? hb2_out[c] :
                           interp == tdu_pkg::INTERP_2X ? hb1_out[c] : chan_in[c];
  end

  // ****************************************
  // coarse modulator
  // ****************************************
  // fs/4 uses even points of fs/8 table
  wire [3:0] c_idx = fs8 ? {coarse_ph_q, 1'b0} : {coarse_ph_q[1:0], 2'h0};
  wire signed [15:0] c_cos = tdu_pkg::cos16(c_idx);
  wire signed [15:0] c_sin_p = tdu_pkg::cos16(4'(c_idx - 4'h4));
  wire signed [15:0] c_sin = neg_tune ? -c_sin_p : c_sin_p;
  logic signed [15:0] mix_i;
  logic signed [15:0] mix_q;

  always_comb begin
    if (!coarse_en) begin
      mix_i = interp_out[0];
      mix_q = interp_out[1];
    end else if (real_mix) begin
      mix_i = tdu_pkg::mac2(interp_out[0], c_cos, 16'sh0000, 16'sh0000);
      mix_q = tdu_pkg::mac2(interp_out[1], c_cos, 16'sh0000, 16'sh0000);
    end else begin
      mix_i = tdu_pkg::mac2(interp_out[0], c_cos, interp_out[1], -c_sin);
      mix_q = tdu_pkg::mac2(interp_out[0], c_sin, interp_out[1], c_cos);
    end
  end

  // ****************************************
  // dac-rate output
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= '0;
      coarse_ph_q <= '0;
      dac_a_code  <= '0;
      dac_b_code  <= '0;
    end else begin
      if (out_en) begin
        cnt_q       <= cnt_q + 2'h1;
        coarse_ph_q <= coarse_ph_q + 3'h1;
      end
      // top dac-width bits, zero in power-down even while halted
      if (out_en || dac_a_pwrdn) begin
        dac_a_code <= dac_a_pwrdn ? '0 : mix_i[15 -: DAC_W];
      end
      if (out_en || dac_b_pwrdn) begin
        dac_b_code <= dac_b_pwrdn ? '0 : mix_q[15 -: DAC_W];
      end
    end
  end

endmodule
`default_nettype wire

// ### bench/tdu_tx_path_checker.sv
// Purpose: port-level assertions for the transmit upconversion path
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes:   bound to every tdu_tx_path instance
`timescale 1ns/100ps
`default_nettype none
module tdu_tx_path_checker #(
  parameter int DAC_W = 14
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             tx_take,
  input wire logic             tx_blank_pin,
  input wire logic [DAC_W-1:0] dac_a_code,
  input wire logic [DAC_W-1:0] dac_b_code,
  input wire logic [9:0]       dac_a_offset,
  input wire logic [9:0]       dac_b_offset,
  input wire logic [4:0]       dac_a_fine_gain,
  input wire logic [4:0]       dac_b_fine_gain,
  input wire logic [7:0]       tx_gain_amp,
  input wire logic             dac_a_pwrdn,
  input wire logic             dac_b_pwrdn
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // bus and datapath properties
  // ****************************************
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_err_unmapped: assert property (psel && penable |->
    pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h1c))
    else $error("error response does not match address");
  a_blank_no_take: assert property (tx_blank_pin[*6] |-> !tx_take)
    else $error("sample taken while blanked");
  a_blank_hold_codes: assert property (
    (tx_blank_pin && $stable(dac_a_pwrdn) && $stable(dac_b_pwrdn))[*7]
    |-> $stable(dac_a_code) && $stable(dac_b_code))
    else $error("dac codes moved while blanked");
  a_pd_zero_a: assert property (dac_a_pwrdn[*2] |-> dac_a_code == '0)
    else $error("dac a code not zero in power-down");
  a_pd_zero_b: assert property (dac_b_pwrdn[*2] |-> dac_b_code == '0)
    else $error("dac b code not zero in power-down");
  a_trim_reset_val: assert property ($rose(presetn) |->
    tx_gain_amp == 8'hff && dac_a_offset == 10'h0 && dac_b_fine_gain == 5'h0)
    else $error("trim outputs not at reset value");
  a_trims_quiet: assert property (!(psel && penable && pwrite) |=>
    $stable({tx_gain_amp, dac_a_offset, dac_b_offset, dac_a_fine_gain,
             dac_b_fine_gain, dac_a_pwrdn, dac_b_pwrdn}))
    else $error("trim output changed without a write");

  c_blank: cover property (tx_blank_pin[*7]);
  c_slverr: cover property (psel && penable && pslverr);
  c_pwrdn: cover property (dac_a_pwrdn ##1 dac_a_pwrdn);
endmodule

bind tdu_tx_path tdu_tx_path_checker #(.DAC_W(DAC_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .tx_take, .tx_blank_pin, .dac_a_code, .dac_b_code, .dac_a_offset,
  .dac_b_offset, .dac_a_fine_gain, .dac_b_fine_gain, .tx_gain_amp,
  .dac_a_pwrdn, .dac_b_pwrdn
);
`default_nettype wire

// ### bench/tdu_bb_src.sv
// Purpose: baseband sample source facing the transmit path
// Assumes: sample is only valid in a cycle where tx_take is high
// Notes:   outside take cycles the lines carry the inverted sample
`timescale 1ns/100ps
`default_nettype none
module tdu_bb_src #(
  parameter int W = 14
) (
  input  wire logic        tx_take,
  input  wire logic        blank_req,
  input  wire logic [W-1:0] i_val,
  input  wire logic [W-1:0] q_val,
  output logic [W-1:0]      tx_i,
  output logic [W-1:0]      tx_q,
  output logic              tx_blank_pin
);
  // ****************************************
  // sample and blanking drive
  // ****************************************
  assign tx_i = tx_take ? i_val : ~i_val;
  assign tx_q = tx_take ? q_val : ~q_val;
  assign tx_blank_pin = blank_req;
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench for the transmit upconversion path
// Assumes: pclk is the dac update clock, constant baseband samples
// Notes:   reset, trim and bus checks first, then mode table, then halt, power-down and reset cases
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int W = 14;
  typedef struct {logic [12:0] c; logic [7:0] f; int tk; int lag; int src; int mul;} tdu_row_t;
  // src 0: dac a, 1: dac b, 2: exact input, 4: settled level (b scaled by mul)
  // fine and hilbert rows run in 4x, relation seen over 4 dac samples
  tdu_row_t rows [14] = '{
    '{13'h0000, 8'h00, 16, 0, 2, 1}, '{13'h0003, 8'h00, 16, 0, 2, 1},
    '{13'h0010, 8'h00, 16, 0, 2, 1}, '{13'h0032, 8'h40, 4, 4, 1, -1},
    '{13'h0032, 8'hc0, 4, 4, 1, 1}, '{13'h0040, 8'h00, 16, 1, 1, -1},
    '{13'h0140, 8'h00, 16, 1, 1, 1}, '{13'h00c0, 8'h00, 16, 4, 0, -1},
    '{13'h0240, 8'h00, 16, 2, 0, -1}, '{13'h0240, 8'h00, 16, 0, 1, 4},
    '{13'h00f2, 8'h40, 4, 4, 1, 1}, '{13'h0001, 8'h00, 8, 0, 4, 1},
    '{13'h0002, 8'h00, 4, 0, 4, 1}, '{13'h0006, 8'h00, 4, 0, 4, 0}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_take, tx_blank_pin, er, ok, kn, blank_req = 1'b0;
  logic [W-1:0] i_val = 14'h0fa0, q_val = 14'h03e8, tx_i, tx_q, dac_a_code, dac_b_code;
  logic [9:0] dac_a_offset, dac_b_offset;
  logic [4:0] dac_a_fine_gain, dac_b_fine_gain;
  logic [7:0] tx_gain_amp;
  logic dac_a_pwrdn, dac_b_pwrdn;
  int n_tests = 0, n_mismatch = 0, cyc = 0, tk, bad, pk, x, d, tol;
  int sa [20];
  int sb [20];

  tdu_tx_path #(.DAC_W(W)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_i, .tx_q, .tx_take, .tx_blank_pin,
    .dac_a_code, .dac_b_code, .dac_a_offset, .dac_b_offset, .dac_a_fine_gain,
    .dac_b_fine_gain, .tx_gain_amp, .dac_a_pwrdn, .dac_b_pwrdn);
  tdu_bb_src #(.W(W)) u_src (.tx_take, .blank_req, .i_val, .q_val, .tx_i, .tx_q,
    .tx_blank_pin);

  always #20 pclk = ~pclk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic ck(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
    ck(er === 1'b0, "write refused");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    ck(rd === e && er === 1'b0, m);
  endtask

  task automatic grab;
    ok = 1'b1;
    kn = 1'b1;
    tk = 0;
    for (int n = 0; n < 20; n++) begin
      @(negedge pclk);
      sa[n] = int'(signed'(dac_a_code));
      sb[n] = int'(signed'(dac_b_code));
      ok &= (dac_a_code === i_val && dac_b_code === q_val);
      kn &= ((^{dac_a_code, dac_b_code}) !== 1'bx);
      if (n < 16) tk += int'(tx_take === 1'b1);
    end
    @(posedge pclk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ck(tx_gain_amp === 8'hff, "gain reset");
    rdc(8'h00, 32'h0, "ctrl reset");
    wr(8'h10, 32'hffff_ffff);
    wr(8'h14, 32'h0015_0155);
    wr(8'h18, 32'h0000_00a5);
    rdc(8'h10, 32'h001f_03ff, "dac a trim readback");
    ck(dac_a_offset === 10'h3ff && dac_a_fine_gain === 5'h1f && dac_b_offset === 10'h155
       && dac_b_fine_gain === 5'h15 && tx_gain_amp === 8'ha5, "trims");
    apb(1'b1, 8'h20, 32'h1);
    ck(er === 1'b1, "unmapped write");
    apb(1'b0, 8'h02, 32'h0);
    ck(er === 1'b1 && rd === 32'h0, "misaligned read");
    foreach (rows[r]) begin
      wr(8'h0c, {24'h0, rows[r].f});
      wr(8'h00, {19'h0, rows[r].c});
      repeat (128) @(posedge pclk);
      grab;
      ck(tk == rows[r].tk, "take rate");
      if (rows[r].src == 2) begin
        ck(ok, "bypass value");
      end else if (rows[r].src < 2) begin
        bad = 0;
        pk = 0;
        tol = (rows[r].tk == 16) ? 12 : 800;
        for (int n = 0; n < 16; n++) begin
          x = (rows[r].src == 1) ? sb[n] : sa[n];
          d = sa[n + rows[r].lag] - rows[r].mul * x;
          if (d > tol || d < -tol) bad++;
          if (sa[n] > pk) pk = sa[n];
        end
        ck(bad == 0 && pk > 1000 && kn, "mix relation");
      end else if (rows[r].src == 4) begin
        bad = 0;
        for (int n = 0; n < 16; n++) begin
          d = sa[n] - int'(i_val);
          x = sb[n] - rows[r].mul * int'(q_val);
          if (d > 600 || d < -600 || x > 200 || x < -200) bad++;
        end
        ck(bad == 0 && kn, "interpolated level");
      end
    end
    wr(8'h00, 32'h0000_0400);
    repeat (4) @(posedge pclk);
    grab;
    ck(tk == 0 && sa[0] == sa[19] && sb[0] == sb[19], "power-down halt");
    rdc(8'h1c, 32'h2, "halt status");
    wr(8'h00, 32'h0);
    blank_req <= 1'b1;
    repeat (8) @(posedge pclk);
    grab;
    ck(tk == 0 && sa[0] == sa[19], "blank halt");
    rdc(8'h1c, 32'h6, "blank status");
    blank_req <= 1'b0;
    repeat (8) @(posedge pclk);
    grab;
    ck(tk == 16, "resume after blank");
    wr(8'h00, 32'h0000_1800);
    repeat (3) @(posedge pclk);
    ck(dac_a_code === 14'h0 && dac_b_code === 14'h0 && dac_a_pwrdn === 1'b1
       && dac_b_pwrdn === 1'b1, "dac power-down");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h0, "ctrl after reset");
    test_done;
  end
endmodule
`default_nettype wire
